// ===== design/scpp_map.vh
// constants of the chain serial port pin block
`ifndef SCPP_MAP_VH
`define SCPP_MAP_VH
`define SCPP_MCLK_HZ 40000000
`define SCPP_WDOG_MIN_MS 1000
`define SCPP_WDOG_MAX_MS 2500
`define SCPP_CMD_BITS 4'h8
`define SCPP_DATA_BITS 5'h10
`define SCPP_CMD_WRITE_CFG 8'h01
`define SCPP_CMD_READ_CFG 8'h02
`define SCPP_CFG_W 14
`define SCPP_CFG_DEFAULT 14'h3000
`define SCPP_CFG_DIS_LSB 0
`define SCPP_CFG_DIS_MSB 11
`define SCPP_CFG_AUX1_BIT 12
`define SCPP_CFG_AUX2_BIT 13
`define SCPP_SYNC_RESET 9'h1FF
`endif

// ===== design/scpp_top.v
// chain serial port pins: pass-through, straps, watchdog, aux pins
`timescale 1ns/100ps
`include "scpp_map.vh"

module scpp_top #(
  parameter [31:0] WDOG_CYCLES = `SCPP_WDOG_MIN_MS * (`SCPP_MCLK_HZ / 1000)
) (
  input wire I_MCLK,
  input wire I_RST_N,
  input wire I_SIGNALLING_STYLE_STRAP,
  input wire I_TOP_OF_CHAIN_STRAP,
  input wire I_SERIAL_CLOCK_IN,
  input wire I_CHIP_SELECT_IN_N,
  input wire I_SERIAL_DATA_IN,
  input wire I_CHAIN_DATA_IO,
  input wire I_AUX_PIN_ONE,
  input wire I_AUX_PIN_TWO,
  input wire I_RX_READY,
  output reg O_CHAIN_SELECT_OUT_N,
  output reg O_CHAIN_SELECT_OUT_OE,
  output reg O_CHAIN_CLOCK_OUT,
  output reg O_CHAIN_CLOCK_OUT_OE,
  output reg O_CHAIN_DATA_IO,
  output reg O_CHAIN_DATA_IO_OE,
  output reg O_SERIAL_DATA_OUT,
  output reg O_SERIAL_DATA_OUT_OE,
  output reg O_SERIAL_DATA_IN,
  output reg O_SERIAL_DATA_IN_OE,
  output reg O_WATCHDOG_ALARM_N,
  output reg O_WATCHDOG_ALARM_N_OE,
  output reg O_AUX_PIN_ONE,
  output reg O_AUX_PIN_ONE_OE,
  output reg O_AUX_PIN_TWO,
  output reg O_AUX_PIN_TWO_OE,
  output reg [11:0] O_DISCHARGE_EN,
  output reg [7:0] O_RX_BYTE,
  output reg O_RX_VALID,
  output reg O_RX_SPACE,
  output reg O_RX_OVERRUN
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;

  reg rst_s1_ff;
  reg rst_n_ff;
  reg [8:0] pin_s1_ff;
  reg [8:0] pin_s2_ff;
  reg sck_prev_ff;
  reg cs_prev_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [4:0] bit_cnt_ff;
  reg [4:0] nxt_bit_cnt;
  reg [15:0] shin_ff;
  reg [15:0] shout_ff;
  reg [15:0] nxt_shout;
  reg [`SCPP_CFG_W-1:0] cfg_ff;
  reg [`SCPP_CFG_W-1:0] nxt_cfg;
  reg kick;
  reg byte_done;
  reg [7:0] byte_val;
  reg [31:0] wdog_cnt_ff;
  reg alarm_ff;
  reg head_v_ff;
  reg tail_v_ff;
  reg [7:0] head_ff;
  reg [7:0] tail_ff;
  reg nh_v;
  reg nt_v;
  reg [7:0] nh;
  reg [7:0] nt;
  reg rd_bit;

  wire [8:0] pin_raw = {I_AUX_PIN_TWO, I_AUX_PIN_ONE, I_CHAIN_DATA_IO, I_SERIAL_DATA_IN, I_CHIP_SELECT_IN_N,
                        I_SERIAL_CLOCK_IN, I_TOP_OF_CHAIN_STRAP, I_SIGNALLING_STYLE_STRAP, 1'b1};
  wire volt_mode = pin_s2_ff[1];
  wire top_chain = pin_s2_ff[2];
  wire sck = pin_s2_ff[3];
  wire cs_n = pin_s2_ff[4];
  wire serial_data_in = pin_s2_ff[5];
  wire chain_in = pin_s2_ff[6];
  wire aux1_lvl = pin_s2_ff[7];
  wire aux2_lvl = pin_s2_ff[8];
  wire sck_rise = sck & ~sck_prev_ff;
  wire sck_fall = ~sck & sck_prev_ff;
  wire cs_fall = ~cs_n & cs_prev_ff;
  wire [15:0] shin_nxt = {shin_ff[14:0], serial_data_in};
  wire wdog_expire = ~alarm_ff & (wdog_cnt_ff == WDOG_CYCLES - 32'h0000_0001);
  wire push_ok = byte_done & O_RX_SPACE;
  wire pop = head_v_ff & I_RX_READY;

  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // every pin but I_RX_READY passes two flip-flops
  always @(posedge I_MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_s1_ff <= `SCPP_SYNC_RESET;
      pin_s2_ff <= `SCPP_SYNC_RESET;
      sck_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      sck_prev_ff <= sck;
      cs_prev_ff <= cs_n;
    end
  end

  // frame decoder
  always @* begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shout = shout_ff;
    nxt_cfg = cfg_ff;
    kick = 1'b0;
    byte_done = 1'b0;
    byte_val = shin_nxt[7:0];
    if (cs_n) begin
      nxt_state = ST_IDLE;
    end else if (cs_fall) begin
      nxt_state = ST_CMD;
      nxt_bit_cnt = 5'h00;
    end else if (sck_rise) begin
      nxt_bit_cnt = bit_cnt_ff + 5'h01;
      case (state_ff)
        ST_CMD: begin
          if (nxt_bit_cnt[3:0] == `SCPP_CMD_BITS) begin
            byte_done = 1'b1;
            nxt_bit_cnt = 5'h00;
            if (shin_nxt[7:0] == `SCPP_CMD_WRITE_CFG) begin
              kick = 1'b1;
              nxt_state = ST_WDATA;
            end else if (shin_nxt[7:0] == `SCPP_CMD_READ_CFG) begin
              kick = 1'b1;
              nxt_state = ST_RDATA;
              nxt_shout = {2'b00, aux2_lvl, aux1_lvl, cfg_ff[11:0]};
            end else begin
              nxt_state = ST_SKIP;
            end
          end
        end
        ST_WDATA: begin
          if (nxt_bit_cnt[2:0] == 3'h0) begin
            byte_done = 1'b1;
          end
          if (nxt_bit_cnt == `SCPP_DATA_BITS) begin
            nxt_cfg = shin_nxt[`SCPP_CFG_W-1:0];
            nxt_state = ST_SKIP;
          end
        end
        // counts read bits so the relay from above starts after the own word
        ST_RDATA: begin
          if (bit_cnt_ff == 5'h1F) begin
            nxt_bit_cnt = bit_cnt_ff;
          end
        end
        default: begin
          nxt_bit_cnt = bit_cnt_ff;
        end
      endcase
    end else if (sck_fall && state_ff == ST_RDATA && bit_cnt_ff != 5'h00) begin
      // first bit stands over the fall that ends the command byte
      nxt_shout = {shout_ff[14:0], 1'b1};
    end
    if (wdog_expire) begin
      nxt_cfg = `SCPP_CFG_DEFAULT;
    end
  end

  always @(posedge I_MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shin_ff <= 16'hFFFF;
      shout_ff <= 16'hFFFF;
      cfg_ff <= `SCPP_CFG_DEFAULT;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      if (sck_rise) begin
        shin_ff <= shin_nxt;
      end
      shout_ff <= nxt_shout;
      cfg_ff <= nxt_cfg;
    end
  end

  always @(posedge I_MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wdog_cnt_ff <= 32'h0000_0000;
      alarm_ff <= 1'b0;
    end else if (kick) begin
      wdog_cnt_ff <= 32'h0000_0000;
      alarm_ff <= 1'b0;
    end else if (wdog_expire) begin
      alarm_ff <= 1'b1;
    end else if (!alarm_ff) begin
      wdog_cnt_ff <= wdog_cnt_ff + 32'h0000_0001;
    end
  end

  // two-entry receive buffer
  always @* begin
    nh_v = head_v_ff;
    nh = head_ff;
    nt_v = tail_v_ff;
    nt = tail_ff;
    if (pop) begin
      nh_v = tail_v_ff;
      nh = tail_ff;
      nt_v = 1'b0;
    end
    if (push_ok) begin
      if (!nh_v) begin
        nh_v = 1'b1;
        nh = byte_val;
      end else begin
        nt_v = 1'b1;
        nt = byte_val;
      end
    end
  end

  always @(posedge I_MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
      head_ff <= 8'h00;
      tail_ff <= 8'h00;
      O_RX_BYTE <= 8'h00;
      O_RX_VALID <= 1'b0;
      O_RX_SPACE <= 1'b1;
      O_RX_OVERRUN <= 1'b0;
    end else begin
      head_v_ff <= nh_v;
      tail_v_ff <= nt_v;
      head_ff <= nh;
      tail_ff <= nt;
      O_RX_BYTE <= nh;
      O_RX_VALID <= nh_v;
      O_RX_SPACE <= ~nt_v;
      O_RX_OVERRUN <= byte_done & ~O_RX_SPACE;
    end
  end

  // read bit: own word first, then what comes down the chain
  always @* begin
    rd_bit = shout_ff[15];
    if (bit_cnt_ff >= `SCPP_DATA_BITS) begin
      rd_bit = top_chain ? 1'b1 : chain_in;
    end
  end

  always @(posedge I_MCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      O_CHAIN_SELECT_OUT_N <= 1'b1;
      O_CHAIN_SELECT_OUT_OE <= 1'b0;
      O_CHAIN_CLOCK_OUT <= 1'b1;
      O_CHAIN_CLOCK_OUT_OE <= 1'b0;
      O_CHAIN_DATA_IO <= 1'b1;
      O_CHAIN_DATA_IO_OE <= 1'b0;
      O_SERIAL_DATA_OUT <= 1'b0;
      O_SERIAL_DATA_OUT_OE <= 1'b0;
      O_SERIAL_DATA_IN <= 1'b1;
      O_SERIAL_DATA_IN_OE <= 1'b0;
      O_WATCHDOG_ALARM_N <= 1'b0;
      O_WATCHDOG_ALARM_N_OE <= 1'b0;
      O_AUX_PIN_ONE <= 1'b0;
      O_AUX_PIN_ONE_OE <= 1'b0;
      O_AUX_PIN_TWO <= 1'b0;
      O_AUX_PIN_TWO_OE <= 1'b0;
      O_DISCHARGE_EN <= 12'h000;
    end else begin
      O_CHAIN_SELECT_OUT_N <= cs_n;
      O_CHAIN_SELECT_OUT_OE <= ~top_chain;
      O_CHAIN_CLOCK_OUT <= sck;
      O_CHAIN_CLOCK_OUT_OE <= ~top_chain;
      O_CHAIN_DATA_IO <= serial_data_in;
      O_CHAIN_DATA_IO_OE <= ~top_chain & ~cs_n & (state_ff != ST_RDATA);
      O_SERIAL_DATA_OUT <= 1'b0;
      O_SERIAL_DATA_OUT_OE <= volt_mode & (state_ff == ST_RDATA) & ~rd_bit;
      // current mode reads back on data in
      O_SERIAL_DATA_IN <= rd_bit;
      O_SERIAL_DATA_IN_OE <= ~volt_mode & (state_ff == ST_RDATA);
      O_WATCHDOG_ALARM_N <= 1'b0;
      O_WATCHDOG_ALARM_N_OE <= alarm_ff | wdog_expire;
      O_AUX_PIN_ONE <= 1'b0;
      O_AUX_PIN_ONE_OE <= ~nxt_cfg[`SCPP_CFG_AUX1_BIT];
      O_AUX_PIN_TWO <= 1'b0;
      O_AUX_PIN_TWO_OE <= ~nxt_cfg[`SCPP_CFG_AUX2_BIT];
      O_DISCHARGE_EN <= nxt_cfg[`SCPP_CFG_DIS_MSB:`SCPP_CFG_DIS_LSB];
    end
  end

endmodule // scpp_top

// ===== tb/scpp_chk_assertions.sv
// checker of the chain port pin block
`timescale 1ns/100ps
module scpp_chk #(parameter int WDOG_CYCLES = 3000) (
  input wire I_MCLK, I_RST_N, I_TOP_OF_CHAIN_STRAP, I_SIGNALLING_STYLE_STRAP,
  input wire I_SERIAL_CLOCK_IN, I_CHIP_SELECT_IN_N, I_SERIAL_DATA_IN,
  input wire O_CHAIN_SELECT_OUT_N, O_CHAIN_SELECT_OUT_OE, O_CHAIN_CLOCK_OUT, O_CHAIN_CLOCK_OUT_OE,
  input wire O_CHAIN_DATA_IO, O_CHAIN_DATA_IO_OE, O_SERIAL_DATA_OUT, O_SERIAL_DATA_OUT_OE,
  input wire O_SERIAL_DATA_IN_OE, O_WATCHDOG_ALARM_N_OE, O_AUX_PIN_ONE_OE, O_AUX_PIN_TWO_OE,
  input wire [11:0] O_DISCHARGE_EN,
  input wire O_RX_VALID, O_RX_SPACE, O_RX_OVERRUN
);
  logic [31:0] fall_ff;
  logic [31:0] low_ff;
  logic cs_ff;
  // cycles since select fell and since it was last low
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fall_ff <= '0;
      low_ff <= '0;
      cs_ff <= 1'b1;
    end else begin
      cs_ff <= I_CHIP_SELECT_IN_N;
      fall_ff <= (cs_ff && !I_CHIP_SELECT_IN_N) ? '0 : fall_ff + (fall_ff < WDOG_CYCLES + 16);
      low_ff <= !I_CHIP_SELECT_IN_N ? '0 : low_ff + (low_ff < WDOG_CYCLES + 16);
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  sel_copy_a: assert property (O_CHAIN_SELECT_OUT_OE |-> O_CHAIN_SELECT_OUT_N == $past(I_CHIP_SELECT_IN_N, 3))
    else $error("chain select not a copy");
  clk_copy_a: assert property (O_CHAIN_CLOCK_OUT_OE |-> O_CHAIN_CLOCK_OUT == $past(I_SERIAL_CLOCK_IN, 3))
    else $error("chain clock not a copy");
  data_up_a: assert property (O_CHAIN_DATA_IO_OE |-> O_CHAIN_DATA_IO == $past(I_SERIAL_DATA_IN, 3))
    else $error("chain data not a copy");
  top_off_a: assert property ($past(I_TOP_OF_CHAIN_STRAP, 3) && $past(I_TOP_OF_CHAIN_STRAP, 4)
    |-> !(O_CHAIN_CLOCK_OUT_OE || O_CHAIN_SELECT_OUT_OE || O_CHAIN_DATA_IO_OE)) else $error("chain outputs on at top");
  wdog_early_a: assert property ($rose(O_WATCHDOG_ALARM_N_OE) |-> fall_ff >= WDOG_CYCLES)
    else $error("alarm too early");
  wdog_late_a: assert property (low_ff == WDOG_CYCLES + 8 |-> O_WATCHDOG_ALARM_N_OE)
    else $error("alarm too late");
  cfg_dflt_a: assert property ($rose(O_WATCHDOG_ALARM_N_OE) |=> O_DISCHARGE_EN == 12'h000
    && !O_AUX_PIN_ONE_OE && !O_AUX_PIN_TWO_OE) else $error("config kept after alarm");
  wdog_kick_a: assert property ($fell(O_WATCHDOG_ALARM_N_OE) |-> low_ff < 8)
    else $error("alarm freed without command");
  volt_read_a: assert property (O_SERIAL_DATA_OUT_OE |-> !O_SERIAL_DATA_OUT && $past(I_SIGNALLING_STYLE_STRAP, 3))
    else $error("open drain misuse");
  curr_read_a: assert property (O_SERIAL_DATA_IN_OE |-> !$past(I_SIGNALLING_STYLE_STRAP, 3))
    else $error("data in driven in voltage mode");
  rx_overrun_a: assert property (O_RX_OVERRUN |-> O_RX_VALID && !$past(O_RX_SPACE))
    else $error("overrun with space");
  alarm_c: cover property ($rose(O_WATCHDOG_ALARM_N_OE));
  overrun_c: cover property (O_RX_OVERRUN);
  read_c: cover property (O_SERIAL_DATA_IN_OE);
endmodule // scpp_chk

// ===== tb/scpp_upper.sv
// model of the chain device above
`timescale 1ns/100ps
module scpp_upper (
  input wire i_mclk,
  input wire i_sel_n,
  input wire i_sck,
  input wire i_line,
  output reg o_data,
  output reg [7:0] o_seen
);
  reg sck_ff = 1'b0;
  initial o_data = 1'b0;
  initial o_seen = 8'h00;
  // takes write data, answers changing on every fall, flips when idle
  always @(posedge i_mclk) begin
    sck_ff <= i_sck;
    if (!i_sel_n && !sck_ff && i_sck)
      o_seen <= {o_seen[6:0], i_line};
    if (i_sel_n || (sck_ff && !i_sck))
      o_data <= ~o_data;
  end
endmodule // scpp_upper

// ===== tb/stack_chain_serial_port_pins_tb.sv
// bench of the chain port pin block
`timescale 1ns/100ps
module stack_chain_serial_port_pins_tb;
  localparam int WD = 3000;
  reg clk = 1'b0, rst_n = 1'b0, style = 1'b1, top_of_chain_strap = 1'b0, sck = 1'b0, cs_n = 1'b1, serial_data_in = 1'b0, rdy = 1'b0;
  wire sel_o, sel_oe, ck_o, ck_oe, cd_o, cd_oe, so_oe, si, si_oe, al_oe, a1_oe, a2_oe, rxv, rxs, rxo, up_d;
  wire [11:0] dis;
  wire [7:0] rxb, seen;
  wire cd_w = cd_oe ? cd_o : up_d;
  int miscompares = 0, samples_checked = 0;
  reg ovr = 1'b0;
  reg [15:0] rd;
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (rxo) ovr <= 1'b1;
  scpp_top #(.WDOG_CYCLES(WD)) DUT (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_SIGNALLING_STYLE_STRAP(style), .I_TOP_OF_CHAIN_STRAP(top_of_chain_strap),
    .I_SERIAL_CLOCK_IN(sck), .I_CHIP_SELECT_IN_N(cs_n), .I_SERIAL_DATA_IN(serial_data_in), .I_CHAIN_DATA_IO(cd_w),
    .I_AUX_PIN_ONE(!a1_oe), .I_AUX_PIN_TWO(!a2_oe), .I_RX_READY(rdy),
    .O_CHAIN_SELECT_OUT_N(sel_o), .O_CHAIN_SELECT_OUT_OE(sel_oe), .O_CHAIN_CLOCK_OUT(ck_o),
    .O_CHAIN_CLOCK_OUT_OE(ck_oe), .O_CHAIN_DATA_IO(cd_o), .O_CHAIN_DATA_IO_OE(cd_oe),
    .O_SERIAL_DATA_OUT(), .O_SERIAL_DATA_OUT_OE(so_oe), .O_SERIAL_DATA_IN(si), .O_SERIAL_DATA_IN_OE(si_oe),
    .O_WATCHDOG_ALARM_N(), .O_WATCHDOG_ALARM_N_OE(al_oe), .O_AUX_PIN_ONE(), .O_AUX_PIN_ONE_OE(a1_oe),
    .O_AUX_PIN_TWO(), .O_AUX_PIN_TWO_OE(a2_oe), .O_DISCHARGE_EN(dis), .O_RX_BYTE(rxb),
    .O_RX_VALID(rxv), .O_RX_SPACE(rxs), .O_RX_OVERRUN(rxo));
  scpp_upper UP (.i_mclk(clk), .i_sel_n(sel_oe ? sel_o : 1'b1), .i_sck(ck_oe & ck_o), .i_line(cd_w),
    .o_data(up_d), .o_seen(seen));
  task automatic chk(input string nm, input [15:0] exp, input [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one select-low frame, read bits sampled before each rise
  task automatic frame(input [7:0] cmd, input [15:0] wd);
    reg [23:0] sh;
    sh = {cmd, wd};
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < 24; i++) begin
      serial_data_in = sh[23 - i];
      tick(4);
      if (i >= 8)
        rd[23 - i] = style ? !so_oe : (si_oe ? si : 1'b1);
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    tick(12);
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25 * 12000);
    miscompares++;
    conclude();
  end
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(8);
    chk("idle", 16'h0001, {al_oe, a1_oe, a2_oe, dis, rxs});
    $display("reset test done");
    frame(8'h01, 16'h0ABC);
    chk("cfg", 16'h3ABC, {a1_oe, a2_oe, dis});
    chk("up", 16'h00BC, seen);
    chk("ovr", 16'h0001, ovr);
    chk("rx0", 16'h0001, rxb);
    rdy = 1'b1;
    tick(1);
    rdy = 1'b0;
    tick(2);
    chk("rx1", 16'h000A, rxb);
    rdy = 1'b1;
    tick(2);
    chk("empty", 16'h0000, rxv);
    $display("write test done");
    frame(8'h02, 16'h0000);
    chk("rd low", 16'h0ABC, rd);
    frame(8'h01, 16'h3ABC);
    chk("aux off", 16'h0000, {a1_oe, a2_oe});
    frame(8'h02, 16'h0000);
    chk("rd high", 16'h3ABC, rd);
    $display("read test done");
    style = 1'b0;
    tick(8);
    frame(8'h02, 16'h0000);
    chk("rd cur", 16'h3ABC, rd);
    style = 1'b1;
    $display("current test done");
    chk("not top", 16'h0003, {sel_oe, ck_oe});
    top_of_chain_strap = 1'b1;
    tick(8);
    frame(8'h02, 16'h0000);
    chk("top", 16'h0000, {sel_oe, ck_oe});
    top_of_chain_strap = 1'b0;
    $display("top test done");
    tick(WD + 40);
    chk("wdog", 16'h4000, {al_oe, a1_oe, a2_oe, dis});
    frame(8'h02, 16'h0000);
    chk("kick", 16'h0000, al_oe);
    chk("rd dflt", 16'h3000, rd);
    $display("watchdog test done");
    conclude();
  end
endmodule // stack_chain_serial_port_pins_tb
bind scpp_top scpp_chk #(.WDOG_CYCLES(WDOG_CYCLES)) chk_i (.*);
